/* File: rtl/acr_pkg.sv */
// constants shared by both ends of the configuration link
// Contract
// RL1 - reset pin high 2 us restores defaults
// RL2 - reset clears converter, data outputs low
// RL3 - host must reset or write defaults first; acr_host still starts a single write before either
// RL4 - without reset, hold pin low, write all
// RL5 - default write order 9,A,B,C,D,E,0,1,F
// RL6 - 16-bit word: 4-bit address, 12-bit data
// RL7 - address E defaults 804, others 000
// RL8 - select frames 16 bits, MSB first
package acr_pkg;
  localparam int          CLK_NS      = 10;
  localparam int          T_RST_NS    = 2000;
  localparam int          RST_CYC     = (T_RST_NS + CLK_NS - 1) / CLK_NS;
  localparam int          HALF_CYC    = 4;
  localparam int          GAP_CYC     = 8;
  localparam int          WORD_BITS   = 16;
  localparam int          ADDR_MSB    = 15;
  localparam int          ADDR_LSB    = 12;
  localparam int          DATA_BITS   = 12;
  localparam int          INIT_LEN    = 9;
  localparam logic [11:0] DEF_E       = 12'h804;
  localparam logic [11:0] DEF_OTHER   = 12'h000;
  localparam logic [3:0]  ADDR_E      = 4'hE;
  // host register offsets and fields
  localparam logic [7:0]  OFS_CTRL    = 8'h00;
  localparam logic [7:0]  OFS_WORD    = 8'h04;
  localparam logic [7:0]  OFS_STATUS  = 8'h08;
  localparam int          CTRL_HWRST  = 0;
  localparam int          CTRL_SWINIT = 1;
  localparam int          CTRL_SINGLE = 2;
  localparam int          STAT_BUSY   = 0;
  localparam int          STAT_DONE   = 1;
  localparam logic [15:0] WORD_RESET  = 16'h0000;

  // default value held by a configuration address
  function automatic logic [11:0] def_data(input logic [3:0] addr);
    def_data = (addr == ADDR_E) ? DEF_E : DEF_OTHER; // RL7
  endfunction

  // address of step idx of the software default write
  function automatic logic [3:0] init_addr(input logic [3:0] idx);
    case (idx) // RL5
      4'h0:    init_addr = 4'h9;
      4'h1:    init_addr = 4'hA;
      4'h2:    init_addr = 4'hB;
      4'h3:    init_addr = 4'hC;
      4'h4:    init_addr = 4'hD;
      4'h5:    init_addr = 4'hE;
      4'h6:    init_addr = 4'h0;
      4'h7:    init_addr = 4'h1;
      default: init_addr = 4'hF;
    endcase
  endfunction
endpackage

/* File: rtl/acr_link_if.sv */
// three-wire programming link plus hardware reset line
`timescale 1ns/1ns
interface acr_link_if;
  logic rst;   // hardware reset, active high
  logic sel_n; // frame select, active low
  logic sclk;  // serial clock, idle low
  logic sdata; // serial data, sampled on sclk rise

  modport dev  (input rst, input sel_n, input sclk, input sdata);
  modport host (output rst, output sel_n, output sclk, output sdata);
endinterface

/* File: rtl/acr_sync.sv */
// two-flop synchroniser with asynchronous preset of a constant
`timescale 1ns/1ns
module acr_sync (
  input  wire logic clk,
  input  wire logic arst,
  input  wire logic d,
  output logic      q
);
  logic stage1;

  // first stage is read only by the second
  always_ff @(posedge clk or posedge arst) begin
    if (arst) begin
      stage1 <= 1'b1;
      q      <= 1'b1;
    end else begin
      stage1 <= d;
      q      <= stage1;
    end
  end
endmodule

/* File: rtl/acr_device.sv */
// converter end: configuration bank on the link clock, data outputs
`timescale 1ns/1ns
module acr_device (
  acr_link_if.dev           link,
  input  wire logic         adc_clk,
  input  wire logic [11:0]  sample_in,
  output logic [11:0]       data_out,
  output logic [191:0]      cfg_flat,
  output logic              conv_clear
);
  logic [11:0] cfg      [16];
  logic [11:0] next_cfg [16];
  logic [14:0] shreg;
  logic [14:0] next_shreg;
  logic [3:0]  bitn;
  logic [3:0]  next_bitn;
  logic [11:0] stage;
  logic [11:0] next_stage;
  logic [11:0] next_data_out;

  // shift count, cleared by the frame's own select
  always_comb begin
    next_bitn  = bitn + 4'h1;
    next_shreg = {shreg[13:0], link.sdata}; // RL8
  end

  always_ff @(posedge link.sclk or posedge link.sel_n) begin
    if (link.sel_n) begin
      bitn  <= 4'h0;
      shreg <= 15'h0000;
    end else begin
      bitn  <= next_bitn;
      shreg <= next_shreg;
    end
  end

  // sixteenth rising edge commits address and data
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      next_cfg[i] = cfg[i];
    end
    if (!link.sel_n && bitn == 4'hF) begin
      next_cfg[shreg[14:11]] = {shreg[10:0], link.sdata}; // RL6
    end
  end

  // hardware reset restores defaults regardless of the link clock
  always_ff @(posedge link.sclk or posedge link.rst) begin
    if (link.rst) begin
      for (int i = 0; i < 16; i++) begin
        cfg[i] <= acr_pkg::def_data(4'(i)); // RL1
      end
    end else begin
      for (int i = 0; i < 16; i++) begin
        cfg[i] <= next_cfg[i];
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 16; i++) begin
      cfg_flat[i*12 +: 12] = cfg[i];
    end
  end

  // converter clear held until two adc clocks after reset release
  acr_sync u_rst_sync (
    .clk  (adc_clk),
    .arst (link.rst),
    .d    (1'b0),
    .q    (conv_clear)
  );

  // two-stage output pipeline, zeroed while clearing
  always_comb begin
    next_stage    = conv_clear ? 12'h000 : sample_in;
    next_data_out = conv_clear ? 12'h000 : stage; // RL2
  end

  always_ff @(posedge adc_clk or posedge link.rst) begin
    if (link.rst) begin
      stage    <= 12'h000;
      data_out <= 12'h000; // RL2
    end else begin
      stage    <= next_stage;
      data_out <= next_data_out;
    end
  end
endmodule

/* File: rtl/acr_host.sv */
// host end: apb command registers, reset pulse and serial writer
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ns
module acr_host (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  acr_link_if.host         link
);
  // one-hot sequencer states
  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_RESET = 6'b000010,
    ST_LOAD  = 6'b000100,
    ST_LOW   = 6'b001000,
    ST_HIGH  = 6'b010000,
    ST_GAP   = 6'b100000
  } acr_state_type;

  // sequencer state and the values it registers next
  acr_state_type state, next_state;
  logic [7:0]  cnt, next_cnt;
  logic [3:0]  bitn, next_bitn;
  logic [3:0]  idx, next_idx;
  logic        init_mode, next_init_mode;
  logic [15:0] shreg, next_shreg;
  logic [15:0] word, next_word;
  logic        done, next_done;
  logic        rst_q, next_rst_q;
  logic        sel_n_q, next_sel_n_q;
  logic        sclk_q, next_sclk_q;
  logic        sdata_q, next_sdata_q;
  logic [31:0] next_prdata;
  logic        wr, rd, hit, busy;
  logic        at_ctrl, at_word, at_status;

  // zero-wait apb handshake and register decode
  assign pready    = 1'b1;
  assign busy      = (state != ST_IDLE);
  assign at_ctrl   = (paddr == acr_pkg::OFS_CTRL);
  assign at_word   = (paddr == acr_pkg::OFS_WORD);
  assign at_status = (paddr == acr_pkg::OFS_STATUS);
  assign hit       = at_ctrl || at_word || at_status;
  assign wr        = psel && penable && pwrite;
  assign rd        = psel && !penable && !pwrite;
  assign pslverr   = psel && penable && !hit;

  // link pins come straight from flip-flops, so no glitch reaches them
  assign link.rst   = rst_q;
  assign link.sel_n = sel_n_q;
  assign link.sclk  = sclk_q;
  assign link.sdata = sdata_q;

  // read data captured in the setup phase, shown in the access phase
  always_comb begin
    next_prdata = 32'h00000000;
    if (rd && at_word) begin
      next_prdata = {16'h0000, word};
    end else if (rd && at_status) begin
      next_prdata[acr_pkg::STAT_BUSY] = busy;
      next_prdata[acr_pkg::STAT_DONE] = done;
    end
  end

  // true on the last cycle of a timed phase lasting len cycles
  function automatic logic phase_end(input logic [7:0] count,
                                     input int         len);
    phase_end = (count == 8'(len - 1));
  endfunction

  // command decode and sequencer
  always_comb begin
    next_state     = state;
    next_cnt       = cnt;
    next_bitn      = bitn;
    next_idx       = idx;
    next_init_mode = init_mode;
    next_shreg     = shreg;
    next_word      = word;
    next_done      = done;
    next_rst_q     = 1'b0;
    next_sel_n_q   = 1'b1;
    next_sclk_q    = 1'b0;
    next_sdata_q   = 1'b0;
    if (wr && at_word) begin
      next_word = pwdata[15:0];
    end
    if (wr && at_status && pwdata[acr_pkg::STAT_DONE]) begin
      next_done = 1'b0;
    end
    case (state)
      ST_IDLE: begin
        next_cnt = 8'h00;
        if (wr && at_ctrl) begin
          if (pwdata[acr_pkg::CTRL_HWRST]) begin
            next_state = ST_RESET;
          end else if (pwdata[acr_pkg::CTRL_SWINIT]) begin
            next_init_mode = 1'b1; // RL4
            next_idx       = 4'h0;
            next_state     = ST_LOAD;
          end else if (pwdata[acr_pkg::CTRL_SINGLE]) begin
            next_init_mode = 1'b0;
            next_state     = ST_LOAD;
          end
        end
      end
      ST_RESET: begin
        next_rst_q = 1'b1;
        next_cnt   = cnt + 8'h01;
        // stop one count later so the pin stands a full RST_CYC periods
        if (cnt == 8'(acr_pkg::RST_CYC)) begin // RL1
          next_rst_q = 1'b0;
          next_state = ST_GAP;
          next_cnt   = 8'h00;
        end
      end
      ST_LOAD: begin
        next_shreg = init_mode
          ? {acr_pkg::init_addr(idx), acr_pkg::def_data(acr_pkg::init_addr(idx))}
          : word; // RL7
        next_bitn  = 4'h0;
        next_cnt   = 8'h00;
        next_state = ST_LOW;
      end
      ST_LOW: begin
        next_sel_n_q = 1'b0;
        next_sdata_q = shreg[acr_pkg::WORD_BITS-1]; // RL8
        next_cnt     = cnt + 8'h01;
        if (phase_end(cnt, acr_pkg::HALF_CYC)) begin
          next_cnt    = 8'h00;
          next_sclk_q = 1'b1;
          next_state  = ST_HIGH;
        end
      end
      ST_HIGH: begin
        next_sel_n_q = 1'b0;
        next_sclk_q  = 1'b1;
        next_sdata_q = shreg[acr_pkg::WORD_BITS-1];
        next_cnt     = cnt + 8'h01;
        if (phase_end(cnt, acr_pkg::HALF_CYC)) begin
          next_cnt    = 8'h00;
          next_sclk_q = 1'b0;
          next_shreg  = {shreg[14:0], 1'b0};
          next_bitn   = bitn + 4'h1;
          if (bitn == 4'(acr_pkg::WORD_BITS - 1)) begin // RL6
            next_state = ST_GAP;
          end else begin
            next_sdata_q = shreg[acr_pkg::WORD_BITS-2];
            next_state   = ST_LOW;
          end
        end
      end
      ST_GAP: begin
        next_cnt = cnt + 8'h01;
        if (phase_end(cnt, acr_pkg::GAP_CYC)) begin
          next_cnt = 8'h00;
          if (init_mode && idx != 4'(acr_pkg::INIT_LEN - 1)) begin
            next_idx   = idx + 4'h1; // RL5
            next_state = ST_LOAD;
          end else begin
            next_done  = 1'b1; // RL3
            next_state = ST_IDLE;
          end
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // register every next value, read data included
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state     <= ST_IDLE;
      prdata    <= 32'h00000000;
      cnt       <= 8'h00;
      bitn      <= 4'h0;
      idx       <= 4'h0;
      init_mode <= 1'b0;
      shreg     <= acr_pkg::WORD_RESET;
      word      <= acr_pkg::WORD_RESET;
      done      <= 1'b0;
      rst_q     <= 1'b0;
      sel_n_q   <= 1'b1;
      sclk_q    <= 1'b0;
      sdata_q   <= 1'b0;
    end else begin
      state     <= next_state;
      prdata    <= next_prdata;
      cnt       <= next_cnt;
      bitn      <= next_bitn;
      idx       <= next_idx;
      init_mode <= next_init_mode;
      shreg     <= next_shreg;
      word      <= next_word;
      done      <= next_done;
      rst_q     <= next_rst_q;
      sel_n_q   <= next_sel_n_q;
      sclk_q    <= next_sclk_q;
      sdata_q   <= next_sdata_q;
    end
  end
endmodule

/* File: tb/acr_link_props.sv */
// timing checks on the configuration link between host and device
`timescale 1ns/1ns
module acr_link_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic rst,
  input wire logic sel_n,
  input wire logic sclk,
  input wire logic sdata
);
  logic [7:0] rst_cnt;
  logic [7:0] next_rst_cnt;
  logic [4:0] bit_cnt;
  logic [4:0] next_bit_cnt;
  logic       sclk_q;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // reset-high cycles, and sclk rises inside the current frame
  always_comb begin
    next_rst_cnt = rst ? rst_cnt + 8'h01 : 8'h00;
    next_bit_cnt = sel_n ? 5'h00 : bit_cnt + {4'h0, sclk & ~sclk_q};
  end

  // register the helper counts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_cnt <= 8'h00;
      bit_cnt <= 5'h00;
      sclk_q  <= 1'b0;
    end else begin
      rst_cnt <= next_rst_cnt;
      bit_cnt <= next_bit_cnt;
      sclk_q  <= sclk;
    end
  end

  chk_rst_width: assert property ($fell(rst) |-> rst_cnt == 8'hC8)
    else $error("reset pulse width wrong");
  chk_rst_quiet: assert property (rst |-> sel_n)
    else $error("frame sent during reset");
  chk_frame_bits: assert property ($rose(sel_n) |-> bit_cnt == 5'h10)
    else $error("frame bit count wrong");
  chk_frame_span: assert property (
    $fell(sel_n) |-> ##[120:140] $rose(sel_n))
    else $error("frame length wrong");
  chk_sclk_idle: assert property (sel_n && $past(sel_n) |-> !sclk)
    else $error("sclk moves outside a frame");
  chk_sclk_high: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk)
    else $error("sclk high phase wrong");
  chk_data_hold: assert property (
    $rose(sclk) |-> $stable(sdata) ##1 $stable(sdata))
    else $error("sdata moves at sclk rise");
  chk_gap_min: assert property ($rose(sel_n) |-> sel_n[*8])
    else $error("gap between frames too short");
endmodule

/* File: tb/tb_adc_config_register_init.sv */
// bench: host and device ends joined by the link
`timescale 1ns/1ns
module tb_adc_config_register_init;
  logic         pclk, presetn, psel, penable, pwrite, adc_clk, err;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, rd;
  logic         pready, pslverr, conv_clear;
  logic [11:0]  data_out, sample_in;
  logic [191:0] cfg_flat;
  logic [15:0]  shreg;
  logic [15:0]  frames[$];
  logic [15:0]  words[2] = '{16'hE123, 16'h0ABC};
  logic [15:0]  seq[9] = '{16'h9000, 16'hA000, 16'hB000, 16'hC000,
    16'hD000, 16'hE804, 16'h0000, 16'h1000, 16'hF000};
  int           miscompares, check_count;

  acr_link_if link();
  acr_host acr_host_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link.host));
  acr_device acr_device_i (.link(link.dev), .adc_clk(adc_clk),
    .sample_in(sample_in), .data_out(data_out), .cfg_flat(cfg_flat),
    .conv_clear(conv_clear));
  acr_link_props acr_link_props_i (.pclk(pclk), .presetn(presetn),
    .rst(link.rst), .sel_n(link.sel_n), .sclk(link.sclk), .sdata(link.sdata));

  // bus clock and unrelated converter clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    adc_clk = 1'b0;
    #3;
    forever #32 adc_clk = ~adc_clk;
  end

  // collect each framed word as it crosses the link
  always @(posedge link.sclk) begin
    if (!link.sel_n) shreg <= {shreg[14:0], link.sdata};
  end
  always @(posedge link.sel_n) frames.push_back(shreg);

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one apb transfer; read data and error taken at the ready edge
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // poll status until done, then clear it
  task automatic wait_done();
    rd = 32'h0;
    while (rd[acr_pkg::STAT_DONE] !== 1'b1) begin
      apb(1'b0, acr_pkg::OFS_STATUS, 32'h0);
    end
    apb(1'b1, acr_pkg::OFS_STATUS, 32'h2);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // cut a hang short
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    complete_run();
  end

  // main sequence
  initial begin
    miscompares = 0;
    check_count = 0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    sample_in = 12'h5A5;
    presetn = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // hardware reset pulse clears converter and restores defaults
    apb(1'b1, acr_pkg::OFS_CTRL, 32'h1);
    repeat (100) @(posedge pclk);
    chk("conv_clear", conv_clear, 32'h1);
    chk("data_out", data_out, 32'h0);
    wait_done();
    for (int a = 0; a < 16; a++) begin
      chk("cfg", cfg_flat[a*12+:12], a == 14 ? 32'h804 : 32'h0);
    end
    repeat (60) @(posedge pclk);
    chk("data_out", data_out, 32'h5A5);
    // single word writes overwrite two defaults
    foreach (words[i]) begin
      apb(1'b1, acr_pkg::OFS_WORD, {16'h0000, words[i]});
      apb(1'b0, acr_pkg::OFS_WORD, 32'h0);
      chk("word", rd, {16'h0000, words[i]});
      frames.delete();
      apb(1'b1, acr_pkg::OFS_CTRL, 32'h4);
      apb(1'b0, acr_pkg::OFS_STATUS, 32'h0);
      chk("busy", rd[acr_pkg::STAT_BUSY], 32'h1);
      // a second start while busy must be ignored
      apb(1'b1, acr_pkg::OFS_CTRL, 32'h4);
      wait_done();
      chk("frames", frames.size(), 32'h1);
      chk("frame", frames[0], words[i]);
      chk("cfg", cfg_flat[words[i][15:12]*12+:12], words[i][11:0]);
    end
    // unmapped address is refused and starts nothing
    frames.delete();
    apb(1'b1, 8'h0C, 32'h4);
    chk("pslverr", err, 32'h1);
    repeat (20) @(posedge pclk);
    chk("frames", frames.size(), 32'h0);
    // software default sequence with reset held low
    apb(1'b1, acr_pkg::OFS_CTRL, 32'h2);
    wait_done();
    chk("count", frames.size(), 32'h9);
    foreach (seq[i]) chk("seq", frames[i], seq[i]);
    chk("cfg_e", cfg_flat[14*12+:12], 32'h804);
    chk("cfg_0", cfg_flat[11:0], 32'h0);
    complete_run();
  end
endmodule
